// ===== rtl/dtkr_regs.svh
// timing counts and tone divisors for the keypad tone and ringer block
// How it works
// - rows one to four give 697..941 Hz
// - columns one to three give 1209..1447 Hz
// - on hook: keypad ignored, no tones
// - one row plus one column: dual tone
// - two rows or two columns: single tone
// - diagonal key pair: no tone
// - column driven high alone: column tone
// - row driven low alone: row tone
// - pitch select low 1200/1500, high 1800/2250
// - ringer driven only after genuine ringing
// - two ringer outputs, differential or single
// - all timing from the resonator rate
// - dialing routes tones, attenuates receive
// - speech circuits on only while off hook
// - alert alternates pitches at 20 Hz
// - up/down counter validates ringing
`ifndef DTKR_REGS_SVH
`define DTKR_REGS_SVH

// ----------------------------------------------------------------
// clock and resonator rates
// ----------------------------------------------------------------
`define DTKR_CLK_HZ 25000000
`define DTKR_RES_HZ 480000
`define DTKR_RES_DIV (`DTKR_CLK_HZ / `DTKR_RES_HZ)
`define DTKR_ALT_HZ 20
`define DTKR_ALT_TICKS (`DTKR_RES_HZ / (2 * `DTKR_ALT_HZ))
`define DTKR_RING_TICKS 4800

// ----------------------------------------------------------------
// tone half periods in resonator ticks
// ----------------------------------------------------------------
`define DTKR_HALF(f) (`DTKR_RES_HZ / (2 * (f)))
`define DTKR_F_ROW1 697
`define DTKR_F_ROW2 770
`define DTKR_F_ROW3 852
`define DTKR_F_ROW4 941
`define DTKR_F_COL1 1209
`define DTKR_F_COL2 1336
`define DTKR_F_COL3 1447
`define DTKR_F_ALO_A 1200
`define DTKR_F_ALO_B 1500
`define DTKR_F_AHI_A 1800
`define DTKR_F_AHI_B 2250

`endif

// ===== rtl/dtkr_pkg.sv
// types shared by the keypad tone and ringer block
package dtkr_pkg;
  // ringing validation states
  typedef enum logic {RING_IDLE, RING_ACTIVE} dtkr_ring_t;
  // which of the two alert pitches is sounding
  typedef enum logic {PITCH_FIRST, PITCH_SECOND} dtkr_pitch_t;
  typedef logic [8:0] dtkr_half_t;
endpackage

// ===== rtl/dtkr_top.sv
// keypad dual tone generator, ringing detector and alerter driver
`timescale 1ns/10ps
`include "dtkr_regs.svh"

// ----------------------------------------------------------------
// square wave divider, one per tone group
// ----------------------------------------------------------------
module dtkr_tone_div (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire dtkr_pkg::dtkr_half_t half,
  output logic wave
);
  import dtkr_pkg::*;
  dtkr_half_t cnt;

  // stopping clears the phase so each tone starts cleanly
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cnt <= 9'h000;
      wave <= 1'b0;
    end else if (tick) begin
      if (cnt >= half - 9'h001) begin
        cnt <= 9'h000;
        wave <= ~wave;
      end else begin
        cnt <= cnt + 9'h001;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module dtkr_top #(
  parameter int RING_TICKS = `DTKR_RING_TICKS,
  parameter int ALT_TICKS = `DTKR_ALT_TICKS,
  // clocks per resonator tick; a bench may shorten it to keep runs brief
  parameter int RES_CLOCKS = `DTKR_RES_DIV
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic offhook_sense,
  input wire logic row_in_1,
  input wire logic row_in_2,
  input wire logic row_in_3,
  input wire logic row_in_4,
  input wire logic col_in_1,
  input wire logic col_in_2,
  input wire logic col_in_3,
  input wire logic alert_pitch_sel,
  input wire logic ring_level,
  output logic tone_low,
  output logic tone_high,
  output logic tx_tone_route,
  output logic rx_attenuate,
  output logic speech_enable,
  output logic ring_detected,
  output logic ringer_out_a,
  output logic ringer_out_b
);
  import dtkr_pkg::*;

  localparam logic [5:0] RES_DIV = 6'(RES_CLOCKS);
  localparam logic [15:0] RING_MAX = 16'(RING_TICKS);
  localparam logic [13:0] ALT_MAX = 14'(ALT_TICKS);

  logic [5:0] res_cnt;
  logic tick;
  logic [3:0] row_act;
  logic [2:0] col_act;
  logic [2:0] nr;
  logic [1:0] nc;
  logic low_on;
  logic high_on;
  dtkr_half_t low_half;
  dtkr_half_t high_half;
  dtkr_half_t alert_half;
  logic [15:0] ring_cnt;
  dtkr_ring_t ring_state;
  logic [13:0] alt_cnt;
  dtkr_pitch_t alt_phase;
  logic alert_wave;

  // ----------------------------------------------------------------
  // resonator rate enable
  // ----------------------------------------------------------------
  // all slower timing hangs off this one tick, never a second clock
  always_ff @(posedge clock) begin
    if (rst) begin
      res_cnt <= 6'h00;
      tick <= 1'b0;
    end else if (res_cnt == RES_DIV - 6'h01) begin
      res_cnt <= 6'h00;
      tick <= 1'b1;
    end else begin
      res_cnt <= res_cnt + 6'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // keypad decode
  // ----------------------------------------------------------------
  // rows select low, columns select high; on hook masks both
  always_comb begin
    row_act = offhook_sense ? ~{row_in_4, row_in_3, row_in_2, row_in_1}
                            : 4'h0;
    col_act = offhook_sense ? {col_in_3, col_in_2, col_in_1}
                            : 3'h0;
    nr = 3'({2'h0, row_act[0]}) + 3'({2'h0, row_act[1]})
       + 3'({2'h0, row_act[2]}) + 3'({2'h0, row_act[3]});
    nc = 2'({1'h0, col_act[0]}) + 2'({1'h0, col_act[1]})
       + 2'({1'h0, col_act[2]});
    // a group sounds only with exactly one line of it active, so a
    // diagonal pair silences both and a shared line keeps one tone
    low_on = (nr == 3'h1);
    high_on = (nc == 2'h1);
  end

  // divisor for the single active line of each group
  always_comb begin
    case (1'b1)
      row_act[0]: low_half = 9'(`DTKR_HALF(`DTKR_F_ROW1));
      row_act[1]: low_half = 9'(`DTKR_HALF(`DTKR_F_ROW2));
      row_act[2]: low_half = 9'(`DTKR_HALF(`DTKR_F_ROW3));
      row_act[3]: low_half = 9'(`DTKR_HALF(`DTKR_F_ROW4));
      default: low_half = 9'(`DTKR_HALF(`DTKR_F_ROW1));
    endcase
    case (1'b1)
      col_act[0]: high_half = 9'(`DTKR_HALF(`DTKR_F_COL1));
      col_act[1]: high_half = 9'(`DTKR_HALF(`DTKR_F_COL2));
      col_act[2]: high_half = 9'(`DTKR_HALF(`DTKR_F_COL3));
      default: high_half = 9'(`DTKR_HALF(`DTKR_F_COL1));
    endcase
  end

  dtkr_tone_div u_low (
    .clock(clock),
    .rst(rst),
    .run(low_on),
    .tick(tick),
    .half(low_half),
    .wave(tone_low)
  );

  dtkr_tone_div u_high (
    .clock(clock),
    .rst(rst),
    .run(high_on),
    .tick(tick),
    .half(high_half),
    .wave(tone_high)
  );

  // ----------------------------------------------------------------
  // hook and dialing path control
  // ----------------------------------------------------------------
  // both path controls move in the same cycle so receive never blares
  always_ff @(posedge clock) begin
    if (rst) begin
      speech_enable <= 1'b0;
      tx_tone_route <= 1'b0;
      rx_attenuate <= 1'b0;
    end else begin
      speech_enable <= offhook_sense;
      tx_tone_route <= low_on || high_on;
      rx_attenuate <= low_on || high_on;
    end
  end

  // ----------------------------------------------------------------
  // ringing validation
  // ----------------------------------------------------------------
  // counter climbs on line energy and decays without it, so short
  // noise bursts never reach the top; off hook it is held clear
  always_ff @(posedge clock) begin
    if (rst || offhook_sense) begin
      ring_cnt <= 16'h0000;
    end else if (tick) begin
      if (ring_level && ring_cnt != RING_MAX) begin
        ring_cnt <= ring_cnt + 16'h0001;
      end else if (!ring_level && ring_cnt != 16'h0000) begin
        ring_cnt <= ring_cnt - 16'h0001;
      end
    end
  end

  // full scale declares ringing, empty ends it: wide hysteresis
  always_ff @(posedge clock) begin
    if (rst || offhook_sense) begin
      ring_state <= RING_IDLE;
    end else begin
      case (ring_state)
        RING_IDLE: if (ring_cnt == RING_MAX) ring_state <= RING_ACTIVE;
        RING_ACTIVE: if (ring_cnt == 16'h0000) ring_state <= RING_IDLE;
        default: ring_state <= RING_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alert warble
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst || ring_state != RING_ACTIVE) begin
      alt_cnt <= 14'h0000;
      alt_phase <= PITCH_FIRST;
    end else if (tick) begin
      if (alt_cnt == ALT_MAX - 14'h0001) begin
        alt_cnt <= 14'h0000;
        alt_phase <= (alt_phase == PITCH_FIRST) ? PITCH_SECOND
                                                : PITCH_FIRST;
      end else begin
        alt_cnt <= alt_cnt + 14'h0001;
      end
    end
  end

  // open pin is read as low by the pad, giving the lower pair
  always_comb begin
    case ({alert_pitch_sel, alt_phase == PITCH_SECOND})
      2'b00: alert_half = 9'(`DTKR_HALF(`DTKR_F_ALO_A));
      2'b01: alert_half = 9'(`DTKR_HALF(`DTKR_F_ALO_B));
      2'b10: alert_half = 9'(`DTKR_HALF(`DTKR_F_AHI_A));
      default: alert_half = 9'(`DTKR_HALF(`DTKR_F_AHI_B));
    endcase
  end

  dtkr_tone_div u_alert (
    .clock(clock),
    .rst(rst),
    .run(ring_state == RING_ACTIVE),
    .tick(tick),
    .half(alert_half),
    .wave(alert_wave)
  );

  // outputs in antiphase; both idle low so either can light a lamp;
  // both are gated by the state so they fall together when ringing ends
  always_ff @(posedge clock) begin
    if (rst) begin
      ring_detected <= 1'b0;
      ringer_out_a <= 1'b0;
      ringer_out_b <= 1'b0;
    end else begin
      ring_detected <= (ring_state == RING_ACTIVE);
      ringer_out_a <= (ring_state == RING_ACTIVE) && alert_wave;
      ringer_out_b <= (ring_state == RING_ACTIVE) && !alert_wave;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_onhook_silent: assert property (@(posedge clock)
    disable iff (rst)
    !offhook_sense [*2] |-> !tone_low && !tone_high && !tx_tone_route)
    else $error("tone present while on hook");
  a_row_divisor: assert property (@(posedge clock) disable iff (rst)
    row_act == 4'h8 |-> low_half == 9'(`DTKR_HALF(`DTKR_F_ROW4)))
    else $error("row four divisor wrong");
  a_col_divisor: assert property (@(posedge clock) disable iff (rst)
    col_act == 3'h2 |-> high_half == 9'(`DTKR_HALF(`DTKR_F_COL2)))
    else $error("column two divisor wrong");
  a_dual_pair: assert property (@(posedge clock) disable iff (rst)
    nr == 3'h1 && nc == 2'h1 |-> low_on && high_on)
    else $error("key did not give dual tone");
  a_shared_single: assert property (@(posedge clock)
    disable iff (rst)
    nr == 3'h2 && nc == 2'h1 |-> !low_on && high_on)
    else $error("two rows did not give column tone alone");
  a_diag_none: assert property (@(posedge clock) disable iff (rst)
    (nr == 3'h2 && nc == 2'h2) [*2] |-> !tone_low && !tone_high)
    else $error("diagonal pair produced a tone");
  a_pitch_low: assert property (@(posedge clock) disable iff (rst)
    !alert_pitch_sel && alt_phase == PITCH_FIRST
      |-> alert_half == 9'(`DTKR_HALF(`DTKR_F_ALO_A)))
    else $error("low alert pair not selected");
  a_ring_gate: assert property (@(posedge clock) disable iff (rst)
    ring_state == RING_IDLE [*2] |-> !ringer_out_a && !ringer_out_b)
    else $error("ringer driven without valid ringing");
  a_ring_anti: assert property (@(posedge clock) disable iff (rst)
    ring_detected && $past(ring_detected) |-> ringer_out_a != ringer_out_b)
    else $error("ringer outputs not in antiphase");
  a_dial_path: assert property (@(posedge clock) disable iff (rst)
    $rose(tone_low) |-> tx_tone_route && rx_attenuate)
    else $error("tone without transmit routing");
  a_speech_hook: assert property (@(posedge clock) disable iff (rst)
    offhook_sense |=> speech_enable)
    else $error("speech not enabled off hook");
  a_alt_rate: assert property (@(posedge clock) disable iff (rst)
    tick && alt_cnt == ALT_MAX - 14'h0001 && ring_state == RING_ACTIVE
      |=> alt_phase != $past(alt_phase))
    else $error("alert pitch did not alternate");
  a_ring_declare: assert property (@(posedge clock)
    disable iff (rst)
    $rose(ring_state == RING_ACTIVE) |-> $past(ring_cnt) == RING_MAX)
    else $error("ringing declared before full count");
endmodule

// ===== bench/dtkr_keypad.sv
// keypad crosspoint and resistor-driven controller model
`timescale 1ns/10ps
module dtkr_keypad (
  input wire logic [11:0] keys,
  input wire logic [3:0] row_drv,
  input wire logic [2:0] col_drv,
  output logic [3:0] row_n,
  output logic [2:0] col
);
  // ----------------------------------------------------------------
  // crosspoint wiring
  // ----------------------------------------------------------------
  // a closed key ties its row low and its column high; a controller
  // drives rows low and columns high through series resistors
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      row_n[r] = ~(row_drv[r] | (|keys[r*3 +: 3]));
    end
    for (int c = 0; c < 3; c++) begin
      col[c] = col_drv[c] | keys[c] | keys[c+3]
             | keys[c+6] | keys[c+9];
    end
  end
endmodule

// ===== bench/test_dtkr_top.sv
// self-checking testbench for the keypad tone and ringer block
`timescale 1ns/10ps
module test_dtkr_top;
  import dtkr_pkg::*;
  logic clock = 1'b0, rst = 1'b1, hook = 1'b1, sel = 1'b0, ring = 1'b0;
  logic [11:0] keys = 12'h000;
  logic [3:0] rdrv = 4'h0, row_n;
  logic [2:0] cdrv = 3'h0, col;
  logic lo, hi, txr, rxa, spe, rdet, ra, rb;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  // resonator tick cut to a quarter so the run stays short; every
  // expected time below is counted in ticks of this length
  localparam int TD = 13;

  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  always #20 clock = ~clock;
  dtkr_keypad pad (.keys(keys), .row_drv(rdrv), .col_drv(cdrv),
    .row_n(row_n), .col(col));
  // short ring validation and alternation keep the run bounded
  dtkr_top #(.RING_TICKS(4), .ALT_TICKS(300), .RES_CLOCKS(TD))
    DUT (.clock(clock),
    .rst(rst), .offhook_sense(hook), .row_in_1(row_n[0]),
    .row_in_2(row_n[1]), .row_in_3(row_n[2]), .row_in_4(row_n[3]),
    .col_in_1(col[0]), .col_in_2(col[1]), .col_in_3(col[2]),
    .alert_pitch_sel(sel), .ring_level(ring), .tone_low(lo),
    .tone_high(hi), .tx_tone_route(txr), .rx_attenuate(rxa),
    .speech_enable(spe), .ring_detected(rdet), .ringer_out_a(ra),
    .ringer_out_b(rb));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // clocks until a wave first goes high; tick phase makes it inexact
  task automatic rise_len(input logic w, output int n);
    n = 1;
    while (n < 20000 && (w ? hi : lo) !== 1'b1) begin
      @(posedge clock);
      #1 n++;
    end
  endtask

  // one key: both groups start with their own half period
  task automatic dual(input int r, input int c, input int hl, input int hh);
    int nl, nh;
    @(negedge clock) keys = 12'h001 << (r * 3 + c);
    @(posedge clock);
    #1 chk(txr === 1'b1 && rxa === 1'b1, "dial routing");
    fork
      rise_len(1'b0, nl);
      rise_len(1'b1, nh);
    join
    chk(nl > hl*TD-TD && nl < hl*TD+2*TD, "low tone period");
    chk(nh > hh*TD-TD && nh < hh*TD+2*TD, "high tone period");
    @(negedge clock) keys = 12'h0;
    @(posedge clock);
    #1 chk({lo, hi, txr, rxa} === 4'h0, "tones stop on release");
  endtask

  // apply a selection and see which groups sound over a window
  task automatic sel_case(input logic [11:0] k, input logic [3:0] rd,
      input logic [2:0] cd, input logic el, input logic eh, input int w);
    int tl, th;
    tl = 0;
    th = 0;
    @(negedge clock) keys = k;
    rdrv = rd;
    cdrv = cd;
    @(posedge clock);
    #1 chk(txr === (el | eh) && rxa === (el | eh), "dial routing");
    repeat (w) begin
      @(posedge clock);
      #1 tl += (lo === 1'b1);
      th += (hi === 1'b1);
    end
    chk((tl != 0) == el && (th != 0) == eh, "tone groups");
    @(negedge clock) keys = 12'h0;
    rdrv = 4'h0;
    cdrv = 3'h0;
    @(posedge clock);
  endtask

  // noise is refused, steady ringing drives the alternating alert
  task automatic ring_case(input logic s, input int ha, input int hb,
      input int n);
    int t, fa, fb;
    fa = 0;
    fb = 0;
    @(negedge clock) hook = 1'b0;
    sel = s;
    ring = 1'b1;
    repeat (2 * TD) @(posedge clock);
    @(negedge clock) ring = 1'b0;
    repeat (4 * TD) @(posedge clock);
    #1 chk({rdet, ra, rb} === 3'h0, "noise refused");
    @(negedge clock) ring = 1'b1;
    t = 0;
    while (rdet !== 1'b1 && t < 500) begin
      @(posedge clock);
      #1 t++;
    end
    chk(t > 3 * TD && t < 4 * TD + 4, "ring validation time");
    for (int i = 0; i < n; i++) begin
      logic v;
      v = ra;
      t = 0;
      while (ra === v && t < 15000) begin
        @(posedge clock);
        #1 t++;
      end
      chk(rb === ~ra && rdet === 1'b1, "ringer pair");
      fa += (t > ha*TD-60 && t < ha*TD+60);
      fb += (t > hb*TD-60 && t < hb*TD+60);
    end
    chk(fa > 0 && (n < 2 || fb > 0), "alert pitches");
    @(negedge clock) hook = 1'b1;
    ring = 1'b0;
    // state clears on the first edge, the registered outputs on the next
    repeat (2) @(posedge clock);
    #1 chk({rdet, ra, rb} === 3'h0, "off hook ends alert");
  endtask

  // ----------------------------------------------------------------
  // hang guard and main sequence
  // ----------------------------------------------------------------
  // ceiling sits well above the expected run of about 43k cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(posedge clock);
    #1 chk(spe === 1'b1, "speech on off hook");
    dual(0, 0, 344, 198);
    dual(1, 1, 311, 179);
    dual(2, 2, 281, 165);
    dual(3, 0, 255, 198);
    sel_case(12'h009, 4'h0, 3'h0, 1'b0, 1'b1, 210*TD);
    sel_case(12'h600, 4'h0, 3'h0, 1'b1, 1'b0, 265*TD);
    sel_case(12'h011, 4'h0, 3'h0, 1'b0, 1'b0, 200*TD);
    sel_case(12'h0, 4'h0, 3'h4, 1'b0, 1'b1, 175*TD);
    sel_case(12'h0, 4'h8, 3'h0, 1'b1, 1'b0, 265*TD);
    @(negedge clock) hook = 1'b0;
    @(posedge clock);
    #1 chk(spe === 1'b0, "speech off on hook");
    sel_case(12'h001, 4'h0, 3'h0, 1'b0, 1'b0, 200*TD);
    ring_case(1'b1, 133, 106, 5);
    ring_case(1'b0, 200, 160, 1);
    end_of_test();
  end
endmodule
